// ===== src/system_power_clock_control.sv
// power modes, wake-up timer, external interrupts, clock divider and vector map
`timescale 1ns/1ps
`default_nettype none
module system_power_clock_control (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic WDT_RESET_I,
    input wire logic OSC_VALID_I,
    input wire logic FLASH_INIT_DONE_I,
    input wire logic PLL_RUNNING_I,
    input wire logic IDLE_REQ_I,
    input wire logic PDOWN_REQ_I,
    input wire logic PERIPH_IRQ_I,
    input wire logic [8:0] EXT_PIN_I,
    input wire logic [8:0] EXT_EDGE_MODE_I,
    input wire logic [8:0] EXT_ACTIVE_HIGH_I,
    input wire logic [8:0] EXT_WAKE_EN_I,
    input wire logic [8:0] EXT_CLEAR_I,
    input wire logic [35:0] EXT_ROUTE_I,
    input wire logic [15:0] PERIPH_OFF_I,
    input wire logic [1:0] DIV_SEL_I,
    input wire logic DIV_SEL_WR_I,
    input wire logic VEC_SEL_I,
    input wire logic VEC_SEL_WR_I,
    output logic INT_RESET_N_O,
    output logic CPU_RUN_O,
    output logic CPU_CLK_EN_O,
    output logic OSC_EN_O,
    output logic PLL_KEEP_O,
    output logic PIN_HOLD_O,
    output logic [15:0] PERIPH_CLK_EN_O,
    output logic PCLK_EN_O,
    output logic [1:0] DIV_SEL_O,
    output logic VEC_SEL_O,
    output logic [31:0] FETCH_ADDR_O,
    output logic [3:0] EXT_IRQ_O,
    output logic [4:0] PWR_STATE_O
);
    sysctl_pkg::pwr_state_t state_r;
    sysctl_pkg::pwr_state_t state_nxt;
    logic [sysctl_pkg::WAKE_W-1:0] wake_cnt_r;
    logic [1:0] div_r;
    logic [1:0] div_cnt_r;
    logic vec_r;
    logic [8:0] req;
    logic [8:0] wake_raw;
    logic [3:0] irq_comb;
    logic wake_hit;
    logic any_irq;
    logic wake_done;
    logic pclk_tick;

    // -------------------------------------------------------------
    // external interrupt channels
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < sysctl_pkg::NUM_EXT_INT; g++) begin : g_ch
            ext_int_ch u_ch (
                .clk_i(MCLK_I),
                .rstn_i(RSTN_I),
                .pin_i(EXT_PIN_I[g]),
                .edge_mode_i(EXT_EDGE_MODE_I[g]),
                .active_high_i(EXT_ACTIVE_HIGH_I[g]),
                .clear_i(EXT_CLEAR_I[g]),
                .req_o(req[g]),
                .wake_o(wake_raw[g])
            );
        end
    endgenerate

    // combine nine requests onto four lines by route masks
    always_comb begin
        for (int k = 0; k < sysctl_pkg::NUM_INT_OUT; k++) begin
            irq_comb[k] = |(req & EXT_ROUTE_I[k*9 +: 9]);
        end
    end

    // clockless wake term: only pins enabled as wake sources
    assign wake_hit = |(wake_raw & EXT_WAKE_EN_I);
    assign any_irq = PERIPH_IRQ_I | (|irq_comb);
    assign wake_done = (wake_cnt_r == sysctl_pkg::WAKE_COUNT);

    // -------------------------------------------------------------
    // power state machine
    // -------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sysctl_pkg::ST_RESET: begin
                // all release conditions together
                if (wake_done && OSC_VALID_I && FLASH_INIT_DONE_I) begin
                    state_nxt = sysctl_pkg::ST_RUN;
                end
            end
            sysctl_pkg::ST_RUN: begin
                if (PDOWN_REQ_I) begin
                    state_nxt = sysctl_pkg::ST_PDOWN;
                end else if (IDLE_REQ_I) begin
                    state_nxt = sysctl_pkg::ST_IDLE;
                end
            end
            sysctl_pkg::ST_IDLE: begin
                if (any_irq) begin
                    state_nxt = sysctl_pkg::ST_RUN;
                end
            end
            sysctl_pkg::ST_PDOWN: begin
                if (wake_hit) begin
                    state_nxt = sysctl_pkg::ST_WAKE;
                end
            end
            sysctl_pkg::ST_WAKE: begin
                if (wake_done && OSC_VALID_I) begin
                    state_nxt = sysctl_pkg::ST_RUN;
                end
            end
            default: state_nxt = sysctl_pkg::ST_RESET;
        endcase
    end

    // state register; watchdog reset restarts the wake-up timer
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= sysctl_pkg::ST_RESET;
        end else if (WDT_RESET_I) begin
            state_r <= sysctl_pkg::ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // -------------------------------------------------------------
    // wake-up timer
    // -------------------------------------------------------------
    // counts only cycles with a valid oscillator, restarts on invalid
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wake_cnt_r <= '0;
        end else if (WDT_RESET_I || state_r == sysctl_pkg::ST_PDOWN || !OSC_VALID_I) begin
            wake_cnt_r <= '0;
        end else if ((state_r == sysctl_pkg::ST_RESET || state_r == sysctl_pkg::ST_WAKE)
                     && !wake_done) begin
            wake_cnt_r <= wake_cnt_r + {{(sysctl_pkg::WAKE_W-1){1'b0}}, 1'b1};
        end else if (state_r == sysctl_pkg::ST_RUN) begin
            wake_cnt_r <= '0;
        end
    end

    // -------------------------------------------------------------
    // divider and vector map settings
    // -------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            div_r <= sysctl_pkg::DIV_RESET;
        end else if (WDT_RESET_I || state_r == sysctl_pkg::ST_RESET) begin
            div_r <= sysctl_pkg::DIV_RESET;
        end else if (DIV_SEL_WR_I && DIV_SEL_I != 2'h3) begin
            div_r <= DIV_SEL_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            vec_r <= sysctl_pkg::VEC_FLASH;
        end else if (WDT_RESET_I || state_r == sysctl_pkg::ST_RESET) begin
            vec_r <= sysctl_pkg::VEC_FLASH;
        end else if (VEC_SEL_WR_I) begin
            vec_r <= VEC_SEL_I;
        end
    end

    // peripheral clock prescale count, frozen in power-down
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            div_cnt_r <= 2'h0;
        end else if (state_r == sysctl_pkg::ST_PDOWN) begin
            div_cnt_r <= div_cnt_r;
        end else if (div_r == sysctl_pkg::DIV_HALF) begin
            div_cnt_r <= {1'b0, ~div_cnt_r[0]};
        end else begin
            div_cnt_r <= div_cnt_r + 2'h1;
        end
    end

    always_comb begin
        unique case (div_r)
            sysctl_pkg::DIV_FULL: pclk_tick = 1'b1;
            sysctl_pkg::DIV_HALF: pclk_tick = (div_cnt_r[0] == 1'b0);
            default: pclk_tick = (div_cnt_r == 2'h0);
        endcase
    end

    // -------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            INT_RESET_N_O <= 1'b0;
            CPU_RUN_O <= 1'b0;
            CPU_CLK_EN_O <= 1'b0;
            OSC_EN_O <= 1'b1;
            PLL_KEEP_O <= 1'b0;
            PIN_HOLD_O <= 1'b0;
            PERIPH_CLK_EN_O <= '0;
            PCLK_EN_O <= 1'b0;
        end else begin
            INT_RESET_N_O <= (state_nxt != sysctl_pkg::ST_RESET) && !WDT_RESET_I;
            CPU_RUN_O <= (state_nxt == sysctl_pkg::ST_RUN) && !WDT_RESET_I;
            // cpu clock stops in idle and power-down
            CPU_CLK_EN_O <= (state_nxt == sysctl_pkg::ST_RUN) && !WDT_RESET_I;
            OSC_EN_O <= (state_nxt != sysctl_pkg::ST_PDOWN);
            PLL_KEEP_O <= (state_nxt == sysctl_pkg::ST_IDLE) && PLL_RUNNING_I;
            PIN_HOLD_O <= (state_nxt == sysctl_pkg::ST_PDOWN)
                          || (state_nxt == sysctl_pkg::ST_WAKE);
            // peripheral clocks run in run and idle, per-peripheral gate
            if (state_nxt == sysctl_pkg::ST_RUN || state_nxt == sysctl_pkg::ST_IDLE) begin
                PERIPH_CLK_EN_O <= ~PERIPH_OFF_I;
                PCLK_EN_O <= pclk_tick;
            end else begin
                PERIPH_CLK_EN_O <= '0;
                PCLK_EN_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DIV_SEL_O <= sysctl_pkg::DIV_RESET;
            VEC_SEL_O <= sysctl_pkg::VEC_FLASH;
            FETCH_ADDR_O <= sysctl_pkg::RESET_VECTOR;
            EXT_IRQ_O <= '0;
            PWR_STATE_O <= sysctl_pkg::ST_RESET;
        end else begin
            DIV_SEL_O <= div_r;
            VEC_SEL_O <= vec_r;
            FETCH_ADDR_O <= sysctl_pkg::RESET_VECTOR;
            EXT_IRQ_O <= irq_comb;
            PWR_STATE_O <= state_r;
        end
    end
endmodule : system_power_clock_control
`default_nettype wire

// ===== common/sysctl_pkg.sv
// constants and types shared by the power and clock control block
// What this block does
// - idle stops execution until reset or interrupt
// - idle keeps peripheral clocks; interrupts resume execution
// - power-down stops oscillator and all clocks
// - power-down keeps state and output pin levels
// - power-down ends on reset or clockless interrupt
// - nine pins, edge/level, into four interrupts
// - each pin may wake from power-down
// - wake-up timer checks oscillator before execution
// - one switch-off control per peripheral
// - peripheral divider gives full, half or quarter rate
// - divider resets to quarter rate
// - pll stays running through idle
// - vectors at zero from flash or ram
// - internal reset held until all conditions met
// - processor starts at address zero after reset
`default_nettype none
package sysctl_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_EXT_INT = 9;
    localparam int NUM_INT_OUT = 4;
    localparam int NUM_PERIPH = 16;
    // ------------------------------------------------------------
    // divider settings
    // ------------------------------------------------------------
    localparam logic [1:0] DIV_QUARTER = 2'h0;
    localparam logic [1:0] DIV_FULL = 2'h1;
    localparam logic [1:0] DIV_HALF = 2'h2;
    localparam logic [1:0] DIV_RESET = DIV_QUARTER;
    // ------------------------------------------------------------
    // vector mapping
    // ------------------------------------------------------------
    localparam logic VEC_FLASH = 1'b0;
    localparam logic VEC_RAM = 1'b1;
    localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
    // ------------------------------------------------------------
    // wake-up timer
    // ------------------------------------------------------------
    localparam int WAKE_CYCLES = 4096;
    localparam int WAKE_W = 13;
    localparam logic [WAKE_W-1:0] WAKE_COUNT = WAKE_W'(WAKE_CYCLES);
    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_RUN = 5'b00010,
        ST_IDLE = 5'b00100,
        ST_PDOWN = 5'b01000,
        ST_WAKE = 5'b10000
    } pwr_state_t;
endpackage : sysctl_pkg
`default_nettype wire

// ===== src/ext_int_ch.sv
// one external interrupt input with edge or level sensing
`timescale 1ns/1ps
`default_nettype none
module ext_int_ch (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    input wire logic edge_mode_i,
    input wire logic active_high_i,
    input wire logic clear_i,
    output logic req_o,
    output logic wake_o
);
    logic prev_r;
    logic flag_r;
    logic act;

    // polarity-adjusted active level
    assign act = pin_i ~^ active_high_i;
    // clockless wake path is the raw active level, no flop involved
    assign wake_o = act;

    // -------------------------------------------------------------
    // edge history
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= act;
        end
    end

    // sticky edge flag, a new edge wins over clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_r <= 1'b0;
        end else if (act && !prev_r) begin
            flag_r <= 1'b1;
        end else if (clear_i) begin
            flag_r <= 1'b0;
        end
    end

    assign req_o = edge_mode_i ? flag_r : act;
endmodule : ext_int_ch
`default_nettype wire

// ===== testbench/osc_flash_model.sv
// oscillator start-up and flash init model feeding the control block
`timescale 1ns/1ps
`default_nettype none
module osc_flash_model #(
    parameter int START = 20
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic osc_en_i,
    output logic osc_valid_o,
    output logic flash_done_o
);
    int cnt;
    // oscillator usable only after a start-up delay, lost when disabled
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i || !osc_en_i) cnt <= 0;
        else if (cnt < START) cnt <= cnt + 1;
    end
    assign osc_valid_o = osc_en_i && (cnt == START);
    // flash init ends a few clocks after the oscillator starts
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) flash_done_o <= 1'b0;
        else flash_done_o <= (cnt > 4);
    end
endmodule : osc_flash_model
`default_nettype wire

// ===== testbench/sysctl_checker.sv
// assertions on the control block's ports
`timescale 1ns/1ps
`default_nettype none
module sysctl_checker (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic OSC_VALID_I,
    input wire logic FLASH_INIT_DONE_I,
    input wire logic INT_RESET_N_O,
    input wire logic CPU_RUN_O,
    input wire logic CPU_CLK_EN_O,
    input wire logic OSC_EN_O,
    input wire logic PLL_KEEP_O,
    input wire logic PIN_HOLD_O,
    input wire logic [15:0] PERIPH_CLK_EN_O,
    input wire logic PCLK_EN_O,
    input wire logic [1:0] DIV_SEL_O,
    input wire logic [31:0] FETCH_ADDR_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [13:0] wk_cnt_r;
    // valid oscillator cycles seen while waking
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) wk_cnt_r <= 14'h0;
        else if (PIN_HOLD_O && OSC_EN_O && OSC_VALID_I) wk_cnt_r <= wk_cnt_r + 14'h1;
        else wk_cnt_r <= 14'h0;
    end
    sequence quarter_s;
        (CPU_RUN_O && DIV_SEL_O == sysctl_pkg::DIV_QUARTER) [*6];
    endsequence
    sequence half_s;
        (CPU_RUN_O && DIV_SEL_O == sysctl_pkg::DIV_HALF) [*4];
    endsequence
    sequence full_s;
        (CPU_RUN_O && DIV_SEL_O == sysctl_pkg::DIV_FULL) [*3];
    endsequence
    // mode and clock relations
    idle_stop_a: assert property (
        PLL_KEEP_O |-> !CPU_RUN_O && !CPU_CLK_EN_O && OSC_EN_O)
        else $error("execution running while idle");
    run_clk_a: assert property (CPU_RUN_O |-> CPU_CLK_EN_O && INT_RESET_N_O && !PIN_HOLD_O)
        else $error("run without clock or released reset");
    pdown_clk_a: assert property (
        !OSC_EN_O |-> !CPU_CLK_EN_O && !PCLK_EN_O && !(|PERIPH_CLK_EN_O))
        else $error("clock delivered in power-down");
    pdown_hold_a: assert property (
        !OSC_EN_O && !$past(OSC_EN_O) |-> PIN_HOLD_O && $stable(DIV_SEL_O))
        else $error("state not held in power-down");
    fetch_zero_a: assert property (FETCH_ADDR_O == sysctl_pkg::RESET_VECTOR)
        else $error("fetch address not zero");
    rst_rel_a: assert property (
        $rose(INT_RESET_N_O) |-> $past(FLASH_INIT_DONE_I) && CPU_RUN_O)
        else $error("reset released before flash ready");
    wake_time_a: assert property (
        $fell(PIN_HOLD_O) |-> wk_cnt_r >= 14'hffa && wk_cnt_r <= 14'h1004)
        else $error("wake time wrong");
    div_rst_a: assert property (
        !INT_RESET_N_O && !$past(INT_RESET_N_O) |-> DIV_SEL_O == 2'h0)
        else $error("divider not quarter in reset");
    quarter_rate_a: assert property (
        quarter_s |-> $countones({$past(PCLK_EN_O, 1), $past(PCLK_EN_O, 2),
        $past(PCLK_EN_O, 3), $past(PCLK_EN_O, 4)}) == 1)
        else $error("quarter rate wrong");
    half_rate_a: assert property (half_s |-> $past(PCLK_EN_O, 1) != $past(PCLK_EN_O, 2))
        else $error("half rate wrong");
    full_rate_a: assert property (full_s |-> $past(PCLK_EN_O))
        else $error("full rate wrong");
endmodule : sysctl_checker
bind system_power_clock_control sysctl_checker sysctl_checker_inst (
    .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .OSC_VALID_I(OSC_VALID_I),
    .FLASH_INIT_DONE_I(FLASH_INIT_DONE_I), .INT_RESET_N_O(INT_RESET_N_O), .CPU_RUN_O(CPU_RUN_O),
    .CPU_CLK_EN_O(CPU_CLK_EN_O), .OSC_EN_O(OSC_EN_O), .PLL_KEEP_O(PLL_KEEP_O),
    .PIN_HOLD_O(PIN_HOLD_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .PCLK_EN_O(PCLK_EN_O),
    .DIV_SEL_O(DIV_SEL_O), .FETCH_ADDR_O(FETCH_ADDR_O));
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the power and clock control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module tb;
    logic clk = 1'b0, rstn = 1'b0, wdt = 1'b0, idle = 1'b0, pdn = 1'b0, pirq = 1'b0, pll = 1'b1;
    logic dwr = 1'b0, vsel = 1'b0, vwr = 1'b0, osc, fld, rn, run, cen, oen, keep, hold, pen, vo;
    logic [8:0] pin = 9'h002, edg = 9'h000, ahi = 9'h1fd, wen = 9'h002, clr = 9'h000;
    logic [35:0] route = 36'h0;
    logic [15:0] poff = 16'h0, pce;
    logic [1:0] dsel = 2'h0, dso;
    logic [31:0] fa;
    logic [3:0] irq;
    logic [4:0] st;
    logic [1:0] dv [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] de [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    int dc [4] = '{8, 4, 4, 2};
    int errors = 0, tests_run = 0, cyc = 0, n;
    system_power_clock_control system_power_clock_control_inst (
        .MCLK_I(clk), .RSTN_I(rstn), .WDT_RESET_I(wdt), .OSC_VALID_I(osc),
        .FLASH_INIT_DONE_I(fld), .PLL_RUNNING_I(pll), .IDLE_REQ_I(idle), .PDOWN_REQ_I(pdn),
        .PERIPH_IRQ_I(pirq), .EXT_PIN_I(pin), .EXT_EDGE_MODE_I(edg), .EXT_ACTIVE_HIGH_I(ahi),
        .EXT_WAKE_EN_I(wen), .EXT_CLEAR_I(clr), .EXT_ROUTE_I(route), .PERIPH_OFF_I(poff),
        .DIV_SEL_I(dsel), .DIV_SEL_WR_I(dwr), .VEC_SEL_I(vsel), .VEC_SEL_WR_I(vwr),
        .INT_RESET_N_O(rn), .CPU_RUN_O(run), .CPU_CLK_EN_O(cen), .OSC_EN_O(oen),
        .PLL_KEEP_O(keep), .PIN_HOLD_O(hold), .PERIPH_CLK_EN_O(pce), .PCLK_EN_O(pen),
        .DIV_SEL_O(dso), .VEC_SEL_O(vo), .FETCH_ADDR_O(fa), .EXT_IRQ_O(irq), .PWR_STATE_O(st));
    osc_flash_model osc_flash_model_inst (.clk_i(clk), .rstn_i(rstn), .osc_en_i(oen),
        .osc_valid_o(osc), .flash_done_o(fld));
    // clock and hang limit
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            results();
        end
    end
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask : tick
    task automatic wait_run(input int lim);
        n = 0;
        while (run !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_run
    task automatic pulses();
        n = 0;
        repeat (8) begin
            tick(1);
            n += int'(pen === 1'b1);
        end
    endtask : pulses
    // one write strobe, divider or vector map
    task automatic wr(input logic [1:0] v, input logic is_vec);
        dsel = v;
        vsel = v[0];
        dwr = !is_vec;
        vwr = is_vec;
        tick(1);
        dwr = 1'b0;
        vwr = 1'b0;
        tick(3);
    endtask : wr
    task automatic results();
        $display("counts errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // main sequence
    initial begin
        tick(5);
        `CHK("int_reset", 1'b0, rn)
        `CHK("div_reset", 2'h0, dso)
        `CHK("vec_reset", 1'b0, vo)
        `CHK("state_reset", 5'h01, st)
        rstn = 1'b1;
        wait_run(6000);
        `CHK("boot_wait", 1'b1, n >= 4116 && n <= 4120)
        `CHK("int_release", 1'b1, rn)
        `CHK("fetch", 32'h0, fa)
        $display("test boot done");
        for (int i = 0; i < 4; i++) begin
            wr(dv[i], 1'b0);
            `CHK("div_sel", de[i], dso)
            pulses();
            `CHK("pclk_count", dc[i], n)
        end
        wr(2'h1, 1'b1);
        `CHK("vec_ram", 1'b1, vo)
        wr(2'h0, 1'b1);
        `CHK("vec_flash", 1'b0, vo)
        poff = 16'h00f0;
        tick(3);
        `CHK("periph_en", 16'hff0f, pce)
        $display("test divider map periph done");
        idle = 1'b1;
        tick(1);
        idle = 1'b0;
        tick(3);
        `CHK("idle_run", 1'b0, run)
        `CHK("idle_state", 5'h04, st)
        `CHK("idle_pll", 1'b1, keep)
        `CHK("idle_periph", 16'hff0f, pce)
        pulses();
        `CHK("idle_pclk", 2, n)
        pirq = 1'b1;
        tick(1);
        pirq = 1'b0;
        wait_run(10);
        `CHK("idle_exit", 1'b1, run)
        $display("test idle done");
        route = 36'h000001020;
        edg = 9'h008;
        tick(2);
        pin[5] = 1'b1;
        tick(3);
        `CHK("level_irq", 4'h1, irq)
        pin[5] = 1'b0;
        tick(3);
        `CHK("level_off", 4'h0, irq)
        pin[3] = 1'b1;
        tick(1);
        pin[3] = 1'b0;
        tick(3);
        `CHK("edge_sticky", 4'h2, irq)
        clr[3] = 1'b1;
        tick(1);
        clr[3] = 1'b0;
        tick(3);
        `CHK("edge_clear", 4'h0, irq)
        pll = 1'b0;
        idle = 1'b1;
        tick(1);
        idle = 1'b0;
        tick(3);
        `CHK("idle_no_pll", 1'b0, keep)
        `CHK("idle_halt", 1'b0, run)
        pin[3] = 1'b1;
        wait_run(10);
        `CHK("idle_ext_exit", 1'b1, run)
        pin[3] = 1'b0;
        clr[3] = 1'b1;
        tick(1);
        clr[3] = 1'b0;
        pll = 1'b1;
        $display("test external interrupts done");
        wr(2'h2, 1'b0);
        `CHK("pd_div_set", 2'h2, dso)
        pdn = 1'b1;
        tick(1);
        pdn = 1'b0;
        tick(3);
        `CHK("pd_osc", 1'b0, oen)
        `CHK("pd_cpu_clk", 1'b0, cen)
        `CHK("pd_periph", 16'h0, pce)
        `CHK("pd_hold", 1'b1, hold)
        pin[5] = 1'b1;
        tick(10);
        `CHK("pd_no_wake", 5'h08, st)
        pin[5] = 1'b0;
        pin[1] = 1'b0;
        wait_run(6000);
        pin[1] = 1'b1;
        `CHK("pd_wake_time", 1'b1, n >= 4116 && n <= 4120)
        `CHK("pd_release", 1'b0, hold)
        `CHK("pd_div_kept", 2'h2, dso)
        $display("test power-down done");
        wr(2'h1, 1'b0);
        wdt = 1'b1;
        tick(1);
        wdt = 1'b0;
        tick(2);
        `CHK("wdt_reset", 1'b0, rn)
        `CHK("wdt_div", 2'h0, dso)
        wait_run(6000);
        `CHK("wdt_resume", 1'b1, run)
        $display("test watchdog reset done");
        results();
    end
endmodule : tb
`default_nettype wire
